// file: sep_defines.vh
// sep_defines.vh: constants for the serial eeprom pin front end
// assumes inclusion by bare name from the design files of this block
`ifndef SEP_DEFINES_VH
`define SEP_DEFINES_VH
// opcodes
`define SEP_OP_WREN 8'h06
`define SEP_OP_WRDI 8'h04
`define SEP_OP_STATUS_READ_COMMAND 8'h05
`define SEP_OP_WRSR 8'h01
`define SEP_OP_READ 8'h03
`define SEP_OP_WRITE 8'h02
// status register fields
`define SEP_SR_BUSY 0
`define SEP_SR_WEL 1
`define SEP_SR_PPE 7
`define SEP_SR_WMASK 8'h8c
`define SEP_SR_RESET 8'h00
// timing at a 50 MHz clock
`define SEP_CLK_MHZ 50
`define SEP_WRITE_TIME_MS 5
`define SEP_WRITE_CYCLES (`SEP_WRITE_TIME_MS * 1000 * `SEP_CLK_MHZ)
`define SEP_POWERUP_TIME_MS 1
`define SEP_POWERUP_CYCLES (`SEP_POWERUP_TIME_MS * 1000 * `SEP_CLK_MHZ)
// fifo
`define SEP_FIFO_DEPTH 8
`define SEP_FIFO_AW 3
`endif

// file: sep_fifo.v
// sep_fifo.v: small synchronous fifo with valid/ready on both sides
// assumes one clock and an already synchronised active-low reset
`timescale 1ns/10ps
`default_nettype none
module sep_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_ff;
  reg [AW:0] rp_ff;
  reg ov_ff;
  wire empty = (wp_ff == rp_ff);
  wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  wire wr = in_valid && !full;
  wire rd = !empty && (!ov_ff || out_ready);
  assign in_ready = !full;
  assign out_valid = ov_ff;

  // memory write; no reset needed for storage
  always @(posedge clk) begin
    if (wr) begin
      mem[wp_ff[AW-1:0]] <= in_data;
    end
  end

  // pointers and registered read port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= {(AW+1){1'b0}};
      rp_ff <= {(AW+1){1'b0}};
      ov_ff <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (wr) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (rd) begin
        rp_ff <= rp_ff + 1'b1;
        out_data <= mem[rp_ff[AW-1:0]];
        ov_ff <= 1'b1;
      end else if (out_ready) begin
        ov_ff <= 1'b0;
      end
    end
  end
endmodule // sep_fifo
`default_nettype wire

// file: sep_core.v
// sep_core.v: pin-level spi front end of a serial eeprom
// assumes host drives cs/sck/si/wp/hold asynchronously; clk much faster than sck
`timescale 1ns/10ps
`default_nettype none
`include "sep_defines.vh"
// What this block does
// - each input bit is sampled on the rising edge of the serial clock in modes 0 and 3.
// - each output bit is changed on the falling edge of the serial clock.
// - with chip select high the output is released and the block idles, but a running write finishes.
// - a high write-protect pin never blocks a write by itself.
// - with write-protect low and protect_pin_enable set, status register writes are rejected.
// - hold low freezes the serial state, which resumes unchanged when hold returns high.
// - the internal write cycle ends within 5 ms of chip select rising after a valid write.
// - during an internal write every command but status_read_command is ignored.
// - protect_pin_enable gates whether a low write-protect pin has any effect.
module sep_core #(
  parameter WRITE_CYCLES = `SEP_WRITE_CYCLES,
  parameter POWERUP_CYCLES = `SEP_POWERUP_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // spi pins
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  input wire hold_n,
  output reg so_o,
  output wire so_oe,
  // memory side: write bytes leave through a fifo, read bytes come in
  output wire wr_valid,
  input wire wr_ready,
  output wire [22:0] wr_data,
  output reg rd_req,
  output reg [14:0] rd_addr,
  input wire [7:0] rd_data,
  // status
  output wire busy,
  output wire ready_for_access,
  output wire [7:0] status
);
  localparam ST_CMD = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_IGN = 4'h8;

  // opcode test used in several places
  function is_op;
    input [7:0] v;
    input [7:0] op;
    begin
      is_op = (v == op);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  reg [1:0] rst_sync_ff;
  wire rst_n = rst_sync_ff[1];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // five pins, each through two flops before use
  wire [4:0] pin_raw = {hold_n, wp_n, si, sck, cs_n};
  reg [4:0] meta_ff;
  reg [4:0] sync_ff;
  reg sck_d_ff;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate
  wire cs_s = sync_ff[0];
  wire sck_s = sync_ff[1];
  wire si_s = sync_ff[2];
  wire wp_s = sync_ff[3];
  wire hold_s = sync_ff[4];
  wire active = !cs_s && hold_s; // hold freezes the serial engine, not the timers
  wire sck_rise = active && sck_s && !sck_d_ff;
  wire sck_fall = active && !sck_s && sck_d_ff;

  //////////////////////////////////////////////////////////////////////
  // session state
  reg [3:0] st_ff;
  reg [3:0] nxt_st;
  reg [7:0] op_ff;
  reg [7:0] sh_ff;
  reg [2:0] bit_ff;
  reg [15:0] addr_ff;
  reg [7:0] sr_ff;
  reg [7:0] tx_ff;
  reg drive_ff;
  reg cs_d_ff;
  reg wr_pend_ff;
  reg [22:0] wcnt_ff;
  reg [16:0] pcnt_ff;
  reg fifo_push;
  wire byte_done = sck_rise && (bit_ff == 3'h7);
  wire [7:0] rx_byte = {sh_ff[6:0], si_s};
  wire cs_rise = cs_s && !cs_d_ff;
  wire busy_w = (wcnt_ff != 23'h000000);
  // the pin blocks sr writes only when pin low and gate bit set
  wire sr_locked = !wp_s && sr_ff[`SEP_SR_PPE];
  wire fifo_in_ready;
  assign busy = busy_w;
  assign status = {sr_ff[7:1], busy_w};
  assign ready_for_access = (pcnt_ff == 17'h00000);
  assign so_oe = drive_ff && active;

  // command decode, honouring the busy lockout
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_CMD: begin
        if (byte_done) begin
          if (busy_w && !is_op(rx_byte, `SEP_OP_STATUS_READ_COMMAND)) begin
            nxt_st = ST_IGN;
          end else if (is_op(rx_byte, `SEP_OP_READ) || is_op(rx_byte, `SEP_OP_WRITE)) begin
            nxt_st = ST_ADDR;
          end else if (is_op(rx_byte, `SEP_OP_STATUS_READ_COMMAND) || is_op(rx_byte, `SEP_OP_WRSR)) begin
            nxt_st = ST_DATA;
          end else begin
            nxt_st = ST_IGN;
          end
        end
      end
      ST_ADDR: begin
        if (byte_done && addr_ff[15]) begin
          nxt_st = ST_DATA; // marker bit reached top: two address bytes in
        end
      end
      ST_DATA: nxt_st = ST_DATA;
      ST_IGN: nxt_st = ST_IGN;
      default: nxt_st = ST_CMD;
    endcase
  end

  // serial engine, framed by chip select
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_CMD;
      op_ff <= 8'h00;
      sh_ff <= 8'h00;
      bit_ff <= 3'h0;
      addr_ff <= 16'h0000;
      sr_ff <= `SEP_SR_RESET;
      tx_ff <= 8'h00;
      drive_ff <= 1'b0;
      so_o <= 1'b0;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      wr_pend_ff <= 1'b0;
      rd_req <= 1'b0;
      rd_addr <= 15'h0000;
      fifo_push <= 1'b0;
    end else begin
      // edge tracker frozen during hold, so a fall that meets hold is seen on resume
      if (cs_s || hold_s) begin
        sck_d_ff <= sck_s;
      end
      cs_d_ff <= cs_s;
      rd_req <= 1'b0;
      fifo_push <= 1'b0;
      // page offset steps on the edge that offers the byte and its address to the fifo, even when a full fifo drops them
      if (fifo_push) begin
        addr_ff[5:0] <= addr_ff[5:0] + 6'h01; // page rollover
      end
      if (cs_s) begin
        // standby: reset framing, release output
        st_ff <= ST_CMD;
        bit_ff <= 3'h0;
        drive_ff <= 1'b0;
        if (cs_rise && op_ff == `SEP_OP_WREN && st_ff == ST_IGN && !busy_w) begin
          sr_ff[`SEP_SR_WEL] <= 1'b1;
        end
        if (cs_rise && op_ff == `SEP_OP_WRDI && st_ff == ST_IGN && !busy_w) begin
          sr_ff[`SEP_SR_WEL] <= 1'b0;
        end
        if (cs_rise && wr_pend_ff) begin
          sr_ff[`SEP_SR_WEL] <= 1'b0;
        end
        wr_pend_ff <= 1'b0;
        op_ff <= 8'h00;
      end else if (hold_s) begin
        st_ff <= nxt_st;
        if (sck_rise) begin
          sh_ff <= rx_byte;
          bit_ff <= bit_ff + 3'h1;
        end
        if (byte_done && st_ff == ST_CMD) begin
          op_ff <= rx_byte;
          addr_ff <= 16'h0001; // marker walks up as address bits arrive
          if (is_op(rx_byte, `SEP_OP_STATUS_READ_COMMAND)) begin
            tx_ff <= {sr_ff[7:1], busy_w};
          end
        end
        if (sck_rise && st_ff == ST_ADDR) begin
          addr_ff <= {addr_ff[14:0], si_s};
        end
        // top address bit is a don't-care, the low fifteen are kept
        if (byte_done && st_ff == ST_ADDR && addr_ff[15] && op_ff == `SEP_OP_READ) begin
          rd_req <= 1'b1;
          rd_addr <= {addr_ff[13:0], si_s};
        end
        if (byte_done && st_ff == ST_ADDR && addr_ff[15]) begin
          addr_ff <= {1'b0, addr_ff[13:0], si_s};
        end
        if (rd_req) begin
          tx_ff <= rd_data;
        end
        if (byte_done && st_ff == ST_DATA && op_ff == `SEP_OP_WRSR) begin
          if (sr_ff[`SEP_SR_WEL] && !sr_locked) begin
            sr_ff <= (sr_ff & ~`SEP_SR_WMASK) | (rx_byte & `SEP_SR_WMASK);
            wr_pend_ff <= 1'b1;
          end
        end
        if (byte_done && st_ff == ST_DATA && op_ff == `SEP_OP_WRITE && sr_ff[`SEP_SR_WEL]) begin
          fifo_push <= 1'b1;
          wr_pend_ff <= 1'b1;
        end
        if (byte_done && st_ff == ST_DATA && op_ff == `SEP_OP_READ) begin
          rd_req <= 1'b1;
          rd_addr <= addr_ff[14:0] + 15'h0001;
          addr_ff[14:0] <= addr_ff[14:0] + 15'h0001;
        end
        if (byte_done && st_ff == ST_DATA && op_ff == `SEP_OP_STATUS_READ_COMMAND) begin
          tx_ff <= {sr_ff[7:1], busy_w};
        end
        if (sck_fall && st_ff == ST_DATA && (op_ff == `SEP_OP_READ || op_ff == `SEP_OP_STATUS_READ_COMMAND)) begin
          drive_ff <= 1'b1;
          so_o <= tx_ff[3'h7 - bit_ff];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write-cycle and power-up timers; the fifo buffers writes when memory is slow
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_ff <= 23'h000000;
      pcnt_ff <= POWERUP_CYCLES[16:0];
    end else begin
      if (cs_rise && wr_pend_ff) begin
        wcnt_ff <= WRITE_CYCLES[22:0];
      end else if (busy_w) begin
        wcnt_ff <= wcnt_ff - 23'h000001; // keeps running in standby
      end
      if (pcnt_ff != 17'h00000) begin
        pcnt_ff <= pcnt_ff - 17'h00001;
      end
    end
  end

  // data bytes are buffered; a full fifo drops late bytes of a burst
  sep_fifo #(
    .WIDTH(23),
    .DEPTH(`SEP_FIFO_DEPTH),
    .AW(`SEP_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({addr_ff[14:0], sh_ff}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );
endmodule // sep_core
`default_nettype wire

// file: sep_core_sva.sv
// sep_core_sva.sv: concurrent checks on the eeprom pin front end
// assumes only the ports of sep_core; attached by the bind below
`timescale 1ns/10ps
`default_nettype none
module sep_core_sva #(
  parameter WRITE_CYCLES = 250000
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // spi pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic wp_n,
  input wire logic hold_n,
  input wire logic so_o,
  input wire logic so_oe,
  // memory side and status
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [22:0] wr_data,
  input wire logic rd_req,
  input wire logic busy,
  input wire logic [7:0] status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [31:0] bcnt_ff;
  wire [31:0] nxt_bcnt = busy ? bcnt_ff + 32'h1 : 32'h0;
  // a counter, since the write time is far beyond any repetition
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bcnt_ff <= 32'h0;
    else bcnt_ff <= nxt_bcnt;
  end
  sequence s_cs_idle; cs_n [*4]; endsequence
  sequence s_hold_on; !hold_n [*4]; endsequence
  a_oe_csoff: assert property (s_cs_idle |-> !so_oe) else $error("so driven while deselected");
  a_oe_hold: assert property (s_hold_on |-> !so_oe) else $error("so driven during hold");
  a_so_edge: assert property (so_oe && $changed(so_o) |-> !$past(sck, 2)) else $error("so moved off a fall");
  a_rd_pulse: assert property (rd_req |=> !rd_req) else $error("read request too long");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data)) else $error("write word lost");
  a_busy_cs: assert property ($rose(busy) |-> cs_n && $past(cs_n)) else $error("write began inside a frame");
  a_busy_max: assert property (bcnt_ff <= WRITE_CYCLES + 2) else $error("write cycle too long");
  a_busy_min: assert property ($fell(busy) |-> bcnt_ff + 3 >= WRITE_CYCLES) else $error("write cycle short");
  a_ppe_lock: assert property (!wp_n && status[7] |=> $stable({status[7], status[3:2]})) else $error("locked status changed");
endmodule // sep_core_sva
bind sep_core sep_core_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck),
  .wp_n(wp_n), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_data(wr_data), .rd_req(rd_req), .busy(busy), .status(status));
`default_nettype wire

// file: sep_host_model.sv
// sep_host_model.sv: host spi controller in mode 0, sck 4 clk low and 4 clk high
// assumes clk is the bench clock; pins move on its falling edge
`timescale 1ns/10ps
`default_nettype none
module sep_host_model (
  // clock
  input wire logic clk,
  // spi pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic wp_n,
  output logic hold_n,
  input wire logic so
);
  logic [7:0] rx;
  event got;
  // idle: deselected, sck low, hold released
  initial {cs_n, sck, si, wp_n, hold_n} = 5'h17;
  // one byte msb first; optional hold before bit hb, with sck low at both hold edges
  task automatic xfer(input logic [7:0] d, input int hb);
    for (int i = 7; i >= 0; i--) begin
      si = d[i];
      if (i == hb) begin
        hold_n = 1'b0;
        repeat (4) @(negedge clk);
        sck = 1'b1; // ignored pulse while held
        repeat (4) @(negedge clk);
        sck = 1'b0;
        repeat (4) @(negedge clk);
        hold_n = 1'b1;
      end
      repeat (4) @(negedge clk);
      sck = 1'b1;
      rx = {rx[6:0], so};
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
  endtask
  // one session: nb bytes of v sent, then nr bytes read back
  task automatic frame(input logic [31:0] v, input int nb, input int nr, input int hb);
    cs_n = 1'b0;
    for (int b = 0; b < nb; b++) xfer(v[31-8*b -: 8], b == 1 ? hb : -1);
    for (int b = 0; b < nr; b++) begin
      xfer(8'h00, -1);
      -> got;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    si = ~si; // released line shows no stale bit
    repeat (8) @(negedge clk);
  endtask
endmodule // sep_host_model
`default_nettype wire

// file: tb_sep_core.sv
// tb_sep_core.sv: self-checking bench for sep_core with a host model and a memory model
// assumes the design files, the host model and the checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("unexpected %0t: %h vs %h", $time, a, e); end end
module tb_sep_core;
  localparam int WC = 200;
  logic clk = 1'b0, nrst = 1'b0, wr_ready = 1'b0, so_q = 1'b0;
  logic [7:0] rd_data = 8'h00, d;
  logic [14:0] ea, a;
  logic [22:0] q[$];
  int n_fail = 0, check_count = 0, seed = 32'h301fa415;
  wire cs_n, sck, si, wp_n, hold_n, so_o, so_oe, wr_valid, rd_req, busy, ready_for_access, so_w;
  wire [22:0] wr_data;
  wire [14:0] rd_addr;
  wire [7:0] status;
  always #10 clk = ~clk;
  // undriven so shows the inverse of its last level
  always @(posedge clk) if (so_oe === 1'b1) so_q <= so_o;
  assign so_w = (so_oe === 1'b1) ? so_o : ~so_q;
  sep_host_model u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n), .so(so_w));
  sep_core #(.WRITE_CYCLES(WC), .POWERUP_CYCLES(50)) dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy),
    .ready_for_access(ready_for_access), .status(status));
  ////////////////////////////////////////
  // memory model: random stalls, a fresh byte after every read request
  always @(negedge clk) begin
    wr_ready = 1'($random(seed));
    if (rd_req === 1'b1) begin
      `CHK(busy, 1'b0)
      `CHK(rd_addr, ea)
      rd_data = 8'($random(seed));
      q.push_back({15'h0, rd_data});
      ea++;
    end
  end
  // result watchers take the oldest note
  // the note is taken once; an empty queue gives an unknown that always mismatches
  task automatic pop(input logic [22:0] v);
    logic [22:0] e;
    e = (q.size() > 0) ? q.pop_front() : 23'hx;
    `CHK(v, e)
  endtask
  always @(posedge clk) if (wr_valid === 1'b1 && wr_ready === 1'b1) pop(wr_data);
  always @(u_host.got) pop({15'h0, u_host.rx});
  task automatic wait_idle;
    for (int i = 0; i < WC + 40 && busy !== 1'b0; i++) @(negedge clk);
    `CHK(busy, 1'b0)
  endtask
  task automatic end_sim;
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #1ms;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (80) @(negedge clk);
    `CHK(ready_for_access, 1'b1)
    u_host.frame({8'h06, 24'h0}, 1, 0, -1);
    q.push_back(23'h02);
    u_host.frame({8'h05, 24'h0}, 1, 1, -1);
    a = 15'($random(seed));
    d = 8'($random(seed));
    q.push_back({a, d});
    u_host.frame({8'h02, 1'b1, a, d}, 4, 0, 3);
    `CHK(busy, 1'b1)
    u_host.frame({8'h03, 24'h0}, 3, 0, -1);
    wait_idle();
    q.push_back(23'h00);
    u_host.frame({8'h05, 24'h0}, 1, 1, -1);
    // status writes against the pin: written value, then what must remain
    for (int k = 0; k < 4; k++) begin
      u_host.wp_n = ~k[0];
      u_host.frame({8'h06, 24'h0}, 1, 0, -1);
      u_host.frame({8'h01, 8'({8'h8c, 8'h00, 8'h04, 8'h08} >> (24 - 8 * k)), 16'h0}, 2, 0, -1);
      // status reads are still served while the write cycle runs: 8c, latch clear, busy set
      if (k == 0) begin
        q.push_back(23'h8d);
        u_host.frame({8'h05, 24'h0}, 1, 1, -1);
      end
      wait_idle();
      `CHK(status & 8'h8c, 8'({8'h8c, 8'h8c, 8'h04, 8'h08} >> (24 - 8 * k)))
    end
    // latch set and then withdrawn leaves status at the last written 08
    u_host.frame({8'h06, 24'h0}, 1, 0, -1);
    u_host.frame({8'h04, 24'h0}, 1, 0, -1);
    q.push_back(23'h08);
    u_host.frame({8'h05, 24'h0}, 1, 1, -1);
    ea = 15'($random(seed));
    u_host.frame({8'h03, 1'b0, ea, 8'h00}, 3, 2, -1);
    end_sim();
  end
endmodule // tb_sep_core
`default_nettype wire
